/* File: inc/pma_pkg.sv */
// Constants and types for program memory table access
package pma_pkg;

	// Special register addresses
	localparam int PMA_SFR_AW = 12;
	localparam logic [PMA_SFR_AW-1:0] PMA_LATCH_ADDR = 12'hff5;
	localparam logic [PMA_SFR_AW-1:0] PMA_PTR_LOW_ADDR = 12'hff6;
	localparam logic [PMA_SFR_AW-1:0] PMA_PTR_HIGH_ADDR = 12'hff7;
	localparam logic [PMA_SFR_AW-1:0] PMA_PTR_UPPER_ADDR = 12'hff8;

	// Pointer layout
	localparam int PMA_DATA_W = 8;
	localparam int PMA_PTR_W = 22;
	localparam int PMA_OFS_W = 21;
	localparam int PMA_ID_BIT = 21;
	localparam int PMA_HIGH_LSB = 8;
	localparam int PMA_UPPER_LSB = 16;
	localparam int PMA_UPPER_USED = 6;
	localparam int PMA_BLOCK_W = 16;
	localparam logic [PMA_OFS_W-1:0] PMA_OFS_ONE = 21'h000001;

	// Reset values
	localparam logic [PMA_DATA_W-1:0] PMA_LATCH_RST = 8'h00;
	localparam logic [PMA_DATA_W-1:0] PMA_BYTE_ZERO = 8'h00;
	localparam logic [PMA_PTR_W-1:0] PMA_PTR_RST = 22'h000000;
	localparam logic [PMA_BLOCK_W-1:0] PMA_BLOCK_RST = 16'h0000;

	typedef enum logic [1:0] {
		PMA_OP_KEEP = 2'b00,
		PMA_OP_POSTINC = 2'b01,
		PMA_OP_POSTDEC = 2'b10,
		PMA_OP_PREINC = 2'b11
	} pma_mode_t;

	typedef enum logic [1:0] {
		PMA_ST_IDLE = 2'b00,
		PMA_ST_READ = 2'b01,
		PMA_ST_PROG = 2'b10
	} pma_state_t;

endpackage

/* File: inc/pma_step_if.sv */
// Pointer step request and result between the table unit and its pointer stepper
`timescale 1ns/1ps
interface pma_step_if;
	import pma_pkg::*;
	logic [PMA_PTR_W-1:0] ptr;
	pma_mode_t mode;
	logic [PMA_PTR_W-1:0] access_addr;
	logic [PMA_PTR_W-1:0] next_ptr;
	modport calc (input ptr, input mode, output access_addr, output next_ptr);
	modport user (output ptr, output mode, input access_addr, input next_ptr);
endinterface

/* File: testbench/pma_mem_model.sv */
// Behavioural program memory array that answers table reads and block writes
`timescale 1ns/1ps
module pma_mem_model
	import pma_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] lat_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [PMA_PTR_W-1:0] addr_i,
	input wire logic [PMA_BLOCK_W-1:0] wdata_i,
	output logic [PMA_DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	output logic wdone_o
);
	logic [7:0] mem [logic [21:0]];
	logic [21:0] a_r;
	logic [15:0] w_r;
	logic rd_r;
	logic [3:0] cnt;
	always @(posedge clk_i) begin
		rvalid_o <= 1'b0;
		wdone_o <= 1'b0;
		// Released data toggles so a stale byte is never mistaken for an answer
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			cnt <= 4'h0;
			rdata_o <= 8'h00;
		end else if (rd_i || wr_i) begin
			a_r <= addr_i;
			w_r <= wdata_i;
			rd_r <= rd_i;
			cnt <= lat_i;
		end else if (cnt == 4'h1) begin
			cnt <= 4'h0;
			if (rd_r) begin
				rvalid_o <= 1'b1;
				rdata_o <= mem.exists(a_r) ? mem[a_r] : a_r[7:0] ^ {a_r[21], 7'h5a};
			end else begin
				mem[{a_r[21:1], 1'b0}] = w_r[7:0];
				mem[{a_r[21:1], 1'b1}] = w_r[15:8];
				wdone_o <= 1'b1;
			end
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the table access unit
`timescale 1ns/1ps
module tb_top;
	import pma_pkg::*;
	logic clk_i, rst_i, sfr_wr_i, sfr_rd_i, sfr_hit_o, op_valid_i, op_write_i, busy_o;
	logic op_done_o, mem_rd_o, mem_wr_o, mem_id_space_o, mem_rvalid_i, mem_wdone_i;
	logic [11:0] sfr_addr_i;
	logic [7:0] sfr_wdata_i, sfr_rdata_o, mem_rdata_i;
	logic [21:0] mem_addr_o, p, acc, nx, ga;
	logic [15:0] mem_wdata_o, gw;
	logic [3:0] lat;
	logic seen, gid;
	pma_mode_t op_mode_i, m;
	int error_cnt = 0;
	int n_checks = 0;
	pma_table_access i_dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
		.sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .op_valid_i(op_valid_i),
		.op_write_i(op_write_i), .op_mode_i(op_mode_i), .busy_o(busy_o), .op_done_o(op_done_o),
		.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
		.mem_id_space_o(mem_id_space_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
		.mem_rvalid_i(mem_rvalid_i), .mem_wdone_i(mem_wdone_i));
	pma_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .rd_i(mem_rd_o),
		.wr_i(mem_wr_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i),
		.rvalid_o(mem_rvalid_i), .wdone_o(mem_wdone_i));
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(negedge clk_i);
		sfr_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic hit);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_rd_i = 1'b1;
		@(negedge clk_i);
		sfr_rd_i = 1'b0;
		chk(24'(sfr_rdata_o), 24'(d));
		chk(24'(sfr_hit_o), 24'(hit));
	endtask
	task automatic set_ptr(input logic [21:0] v);
		wr(PMA_PTR_LOW_ADDR, v[7:0]);
		wr(PMA_PTR_HIGH_ADDR, v[15:8]);
		wr(PMA_PTR_UPPER_ADDR, {2'b00, v[21:16]});
	endtask
	task automatic ptr_is(input logic [21:0] v);
		rd(PMA_PTR_LOW_ADDR, v[7:0], 1'b1);
		rd(PMA_PTR_HIGH_ADDR, v[15:8], 1'b1);
		rd(PMA_PTR_UPPER_ADDR, {2'b00, v[21:16]}, 1'b1);
	endtask
	task automatic wait_done();
		int i;
		seen = 1'b0;
		for (i = 0; i < 40 && op_done_o !== 1'b1; i++) begin
			if (mem_rd_o === 1'b1 || mem_wr_o === 1'b1) begin
				seen = 1'b1;
				ga = mem_addr_o;
				gw = mem_wdata_o;
				gid = mem_id_space_o;
			end
			@(negedge clk_i);
		end
		if (i == 40) begin
			error_cnt++;
			end_of_test();
		end
	endtask
	task automatic op(input logic w, input pma_mode_t md);
		@(negedge clk_i);
		op_valid_i = 1'b1;
		op_write_i = w;
		op_mode_i = md;
		@(negedge clk_i);
		op_valid_i = 1'b0;
		wait_done();
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		{sfr_addr_i, sfr_wr_i, sfr_rd_i, sfr_wdata_i, op_valid_i, op_write_i} = '0;
		op_mode_i = PMA_OP_KEEP;
		lat = 4'h1;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		rd(PMA_LATCH_ADDR, 8'h00, 1'b1);
		ptr_is(22'h000000);
		rd(12'hff4, 8'h00, 1'b0);
		wr(PMA_PTR_UPPER_ADDR, 8'hff);
		rd(PMA_PTR_UPPER_ADDR, 8'h3f, 1'b1);
		// Every mode, at the low end of the 21-bit range without the id bit and at the high end with it
		for (int k = 0; k < 8; k++) begin
			m = pma_mode_t'(k[1:0]);
			p = k[2] ? 22'h3fffff : 22'h000000;
			acc = (m == PMA_OP_PREINC) ? {p[21], p[20:0] + 21'h1} : p;
			nx = (m == PMA_OP_POSTDEC) ? {p[21], p[20:0] - 21'h1} : {p[21], p[20:0] + 21'h1};
			nx = (m == PMA_OP_KEEP) ? p : nx;
			lat = k[2] ? 4'h5 : 4'h1;
			set_ptr(p);
			op(1'b0, m);
			chk(24'(seen), 24'h1);
			chk(24'(ga), 24'(acc));
			chk(24'(gid), 24'(p[21]));
			rd(PMA_LATCH_ADDR, acc[7:0] ^ {acc[21], 7'h5a}, 1'b1);
			ptr_is(nx);
		end
		// Byte pair written even then odd, read back
		set_ptr(22'h000100);
		wr(PMA_LATCH_ADDR, 8'ha5);
		op(1'b1, PMA_OP_POSTINC);
		chk(24'(seen), 24'h0);
		ptr_is(22'h000101);
		wr(PMA_LATCH_ADDR, 8'h3c);
		op(1'b1, PMA_OP_KEEP);
		chk(24'(ga), 24'h000101);
		chk(24'(gw), 24'h003ca5);
		op(1'b0, PMA_OP_POSTDEC);
		rd(PMA_LATCH_ADDR, 8'h3c, 1'b1);
		op(1'b0, PMA_OP_KEEP);
		rd(PMA_LATCH_ADDR, 8'ha5, 1'b1);
		// Holding byte survives low pointer and latch register writes
		wr(PMA_PTR_LOW_ADDR, 8'h01);
		wr(PMA_LATCH_ADDR, 8'h77);
		op(1'b1, PMA_OP_KEEP);
		chk(24'(gw), 24'h0077a5);
		// Write variants: pre-increment even and odd, then post-decrement odd
		set_ptr(22'h0001ff);
		wr(PMA_LATCH_ADDR, 8'h11);
		op(1'b1, PMA_OP_PREINC);
		chk(24'(seen), 24'h0);
		ptr_is(22'h000200);
		wr(PMA_LATCH_ADDR, 8'h22);
		op(1'b1, PMA_OP_PREINC);
		chk(24'(seen), 24'h1);
		chk(24'(ga), 24'h000201);
		chk(24'(gw), 24'h002211);
		ptr_is(22'h000201);
		wr(PMA_LATCH_ADDR, 8'h33);
		op(1'b1, PMA_OP_POSTDEC);
		chk(24'(ga), 24'h000201);
		chk(24'(gw), 24'h003311);
		ptr_is(22'h000200);
		// Requests while busy are dropped
		lat = 4'h6;
		set_ptr(22'h000040);
		@(negedge clk_i);
		op_valid_i = 1'b1;
		op_write_i = 1'b0;
		op_mode_i = PMA_OP_POSTINC;
		@(negedge clk_i);
		chk(24'(busy_o), 24'h1);
		repeat (2) @(negedge clk_i);
		op_valid_i = 1'b0;
		wait_done();
		ptr_is(22'h000041);
		end_of_test();
	end
endmodule

/* File: verilog/pma_ptr_step.sv */
// Pointer stepper: access address and updated pointer for each table mode
`timescale 1ns/1ps
module pma_ptr_step
	import pma_pkg::*;
(
	pma_step_if.calc st
);
	wire [PMA_OFS_W-1:0] ofs_inc;
	wire [PMA_OFS_W-1:0] ofs_dec;
	wire [PMA_PTR_W-1:0] ptr_inc;
	wire [PMA_PTR_W-1:0] ptr_dec;

	// Only the offset wraps; the space select bit rides along untouched
	assign ofs_inc = st.ptr[PMA_OFS_W-1:0] + PMA_OFS_ONE;
	assign ofs_dec = st.ptr[PMA_OFS_W-1:0] - PMA_OFS_ONE;
	assign ptr_inc = {st.ptr[PMA_ID_BIT], ofs_inc};
	assign ptr_dec = {st.ptr[PMA_ID_BIT], ofs_dec};

	assign st.access_addr = (st.mode == PMA_OP_PREINC) ? ptr_inc : st.ptr;
	assign st.next_ptr = (st.mode == PMA_OP_KEEP) ? st.ptr :
		(st.mode == PMA_OP_POSTDEC) ? ptr_dec : ptr_inc;
endmodule

/* File: verilog/pma_table_access.sv */
// Table access unit: latch, 22-bit pointer and program memory transfers
//
// Behaviour
// - An 8-bit latch special register carries each byte of a table transfer.
// - Upper, high and low pointer bytes form one 22-bit program byte address.
// - The lower 21 pointer bits pick a byte in up to 2 Mbytes.
// - Pointer bit 21 switches table accesses to the identification space.
// - Automatic pointer updates change only the lower 21 bits.
// - Plain read and write access the pointer and leave it unchanged.
// - Post-increment variants access the pointer, then add one.
// - Post-decrement variants access the pointer, then subtract one.
// - Pre-increment variants add one first, then access the new address.
// - Each table read fetches one byte into the latch.
// - Memory is programmed in two-byte blocks, one byte per table write.
// - An even-address write copies the latch to the holding byte only.
// - The holding byte cannot be read or written by software.
// - An odd-address write starts a long write of the block.
// - Long write puts latch in the high byte, holding byte in low.
`timescale 1ns/1ps
module pma_table_access
	import pma_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Special register port
	input wire logic [PMA_SFR_AW-1:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [PMA_DATA_W-1:0] sfr_wdata_i,
	output logic [PMA_DATA_W-1:0] sfr_rdata_o,
	output logic sfr_hit_o,
	// Table operation request from the core
	input wire logic op_valid_i,
	input wire logic op_write_i,
	input wire pma_mode_t op_mode_i,
	output logic busy_o,
	output logic op_done_o,
	// Program memory array side
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [PMA_PTR_W-1:0] mem_addr_o,
	output logic mem_id_space_o,
	output logic [PMA_BLOCK_W-1:0] mem_wdata_o,
	input wire logic [PMA_DATA_W-1:0] mem_rdata_i,
	input wire logic mem_rvalid_i,
	input wire logic mem_wdone_i
);

	// Address decode used for every register
	function automatic logic sfr_match(
		input logic [PMA_SFR_AW-1:0] addr,
		input logic [PMA_SFR_AW-1:0] target
	);
		sfr_match = (addr == target);
	endfunction

	// State
	pma_state_t state_r;
	pma_state_t state_nxt;
	logic busy_r;
	logic busy_nxt;
	logic [PMA_DATA_W-1:0] latch_r;
	logic [PMA_DATA_W-1:0] latch_nxt;
	logic [PMA_PTR_W-1:0] ptr_r;
	logic [PMA_PTR_W-1:0] ptr_nxt;
	logic [PMA_PTR_W-1:0] ptr_sw;
	logic mem_rd_r;
	logic mem_wr_r;
	logic [PMA_PTR_W-1:0] mem_addr_r;
	logic [PMA_PTR_W-1:0] mem_addr_nxt;
	logic mem_id_r;
	logic [PMA_BLOCK_W-1:0] wdata_r;
	logic [PMA_BLOCK_W-1:0] wdata_nxt;
	logic [PMA_DATA_W-1:0] rdata_r;
	logic [PMA_DATA_W-1:0] rdata_nxt;
	logic hit_r;
	logic done_r;
	logic done_nxt;

	// Decode
	wire sel_latch;
	wire sel_low;
	wire sel_high;
	wire sel_upper;
	wire sel_any;
	wire wr_latch;
	wire wr_low;
	wire wr_high;
	wire wr_upper;
	wire [PMA_DATA_W-1:0] upper_view;
	wire [PMA_DATA_W-1:0] rd_mux;

	// Operation control
	wire idle;
	wire accept;
	wire rd_go;
	wire wr_go;
	wire wr_short;
	wire wr_long;
	wire read_back;
	wire prog_end;
	wire [PMA_DATA_W-1:0] hold_byte;

	pma_step_if step ();

	pma_ptr_step u_step (
		.st(step.calc)
	);

	pma_wr_pair u_pair (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr_go),
		.addr_lsb_i(step.access_addr[0]),
		.latch_i(latch_r),
		.short_o(wr_short),
		.long_o(wr_long),
		.hold_o(hold_byte)
	);

	assign sel_latch = sfr_match(sfr_addr_i, PMA_LATCH_ADDR);
	assign sel_low = sfr_match(sfr_addr_i, PMA_PTR_LOW_ADDR);
	assign sel_high = sfr_match(sfr_addr_i, PMA_PTR_HIGH_ADDR);
	assign sel_upper = sfr_match(sfr_addr_i, PMA_PTR_UPPER_ADDR);
	assign sel_any = sel_latch | sel_low | sel_high | sel_upper;
	assign wr_latch = sfr_wr_i & sel_latch;
	assign wr_low = sfr_wr_i & sel_low;
	assign wr_high = sfr_wr_i & sel_high;
	assign wr_upper = sfr_wr_i & sel_upper;

	// Unused upper bits above the space select read as zero
	assign upper_view = {{(PMA_DATA_W - PMA_UPPER_USED){1'b0}},
		ptr_r[PMA_PTR_W-1:PMA_UPPER_LSB]};
	assign rd_mux = sel_latch ? latch_r :
		sel_low ? ptr_r[PMA_HIGH_LSB-1:0] :
		sel_high ? ptr_r[PMA_UPPER_LSB-1:PMA_HIGH_LSB] :
		sel_upper ? upper_view : PMA_BYTE_ZERO;
	assign rdata_nxt = sfr_rd_i ? rd_mux : PMA_BYTE_ZERO;

	// A new operation is taken only while nothing is outstanding
	assign idle = (state_r == PMA_ST_IDLE);
	assign accept = op_valid_i & idle;
	assign rd_go = accept & ~op_write_i;
	assign wr_go = accept & op_write_i;
	assign read_back = (state_r == PMA_ST_READ) & mem_rvalid_i;
	assign prog_end = (state_r == PMA_ST_PROG) & mem_wdone_i;

	assign step.ptr = ptr_r;
	assign step.mode = op_mode_i;

	// Software pointer writes, one byte lane each
	assign ptr_sw = {
		wr_upper ? sfr_wdata_i[PMA_UPPER_USED-1:0] : ptr_r[PMA_PTR_W-1:PMA_UPPER_LSB],
		wr_high ? sfr_wdata_i : ptr_r[PMA_UPPER_LSB-1:PMA_HIGH_LSB],
		wr_low ? sfr_wdata_i : ptr_r[PMA_HIGH_LSB-1:0]
	};

	// An accepted operation's pointer update wins over a same-cycle register write
	assign ptr_nxt = accept ? step.next_ptr : ptr_sw;

	// Fetched byte wins over a same-cycle software write
	assign latch_nxt = read_back ? mem_rdata_i :
		wr_latch ? sfr_wdata_i : latch_r;

	// Full access address, bit 21 selecting the identification space
	assign mem_addr_nxt = (rd_go | wr_long) ? step.access_addr : mem_addr_r;
	assign wdata_nxt = wr_long ? {latch_r, hold_byte} : wdata_r;

	assign state_nxt = (idle & rd_go) ? PMA_ST_READ :
		(idle & wr_long) ? PMA_ST_PROG :
		(read_back | prog_end) ? PMA_ST_IDLE : state_r;
	assign busy_nxt = (state_nxt != PMA_ST_IDLE);
	assign done_nxt = wr_short | read_back | prog_end;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= PMA_ST_IDLE;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_r <= PMA_LATCH_RST;
			ptr_r <= PMA_PTR_RST;
		end else begin
			latch_r <= latch_nxt;
			ptr_r <= ptr_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_rd_r <= 1'b0;
			mem_wr_r <= 1'b0;
			mem_addr_r <= PMA_PTR_RST;
			mem_id_r <= 1'b0;
			wdata_r <= PMA_BLOCK_RST;
		end else begin
			mem_rd_r <= rd_go;
			mem_wr_r <= wr_long;
			mem_addr_r <= mem_addr_nxt;
			mem_id_r <= mem_addr_nxt[PMA_ID_BIT];
			wdata_r <= wdata_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= PMA_BYTE_ZERO;
			hit_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			hit_r <= sfr_rd_i & sel_any;
		end
	end

	assign sfr_rdata_o = rdata_r;
	assign sfr_hit_o = hit_r;
	assign busy_o = busy_r;
	assign op_done_o = done_r;
	assign mem_rd_o = mem_rd_r;
	assign mem_wr_o = mem_wr_r;
	assign mem_addr_o = mem_addr_r;
	assign mem_id_space_o = mem_id_r;
	assign mem_wdata_o = wdata_r;

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_latch_sw_write: assert property (
		wr_latch && !read_back |=> latch_r == $past(sfr_wdata_i))
		else $error("latch did not take software write");
	a_upper_byte_map: assert property (
		wr_upper && !accept |=> ptr_r[PMA_PTR_W-1:PMA_UPPER_LSB]
			== $past(sfr_wdata_i[PMA_UPPER_USED-1:0]))
		else $error("upper pointer byte write lost");
	a_id_bit_kept: assert property (
		accept |=> ptr_r[PMA_ID_BIT] == $past(ptr_r[PMA_ID_BIT]))
		else $error("pointer update touched space select bit");
	a_id_space_out: assert property (
		rd_go |=> mem_id_space_o == $past(ptr_r[PMA_ID_BIT]))
		else $error("space select not presented to memory");
	a_plain_keeps: assert property (
		accept && op_mode_i == PMA_OP_KEEP |=> $stable(ptr_r))
		else $error("plain access moved pointer");
	a_postinc_step: assert property (
		rd_go && op_mode_i == PMA_OP_POSTINC |=>
			mem_addr_o == $past(ptr_r)
			&& ptr_r[PMA_OFS_W-1:0] == 21'($past(ptr_r[PMA_OFS_W-1:0]) + PMA_OFS_ONE))
		else $error("post-increment address or step wrong");
	a_postdec_step: assert property (
		rd_go && op_mode_i == PMA_OP_POSTDEC |=>
			mem_addr_o == $past(ptr_r)
			&& ptr_r[PMA_OFS_W-1:0] == 21'($past(ptr_r[PMA_OFS_W-1:0]) - PMA_OFS_ONE))
		else $error("post-decrement address or step wrong");
	a_preinc_addr: assert property (
		rd_go && op_mode_i == PMA_OP_PREINC |=> mem_addr_o == ptr_r
			&& mem_addr_o[PMA_OFS_W-1:0] == 21'($past(ptr_r[PMA_OFS_W-1:0]) + PMA_OFS_ONE))
		else $error("pre-increment did not access updated address");
	a_read_fetch: assert property (
		rd_go |=> mem_rd_o && busy_o ##1 !mem_rd_o)
		else $error("read request not a single pulse");
	a_read_load: assert property (
		read_back |=> latch_r == $past(mem_rdata_i) && !busy_o && op_done_o)
		else $error("fetched byte not loaded into latch");
	a_short_no_prog: assert property (
		wr_short |=> !mem_wr_o && !busy_o && op_done_o)
		else $error("even write started programming");
	a_long_block: assert property (
		wr_long |=> mem_wr_o && busy_o
			&& mem_wdata_o == {$past(latch_r), $past(hold_byte)} ##1 !mem_wr_o)
		else $error("long write block wrong");
	a_prog_holds: assert property (
		state_r == PMA_ST_PROG && !mem_wdone_i |=> busy_o
			&& ($stable(ptr_r) || $past(wr_low || wr_high || wr_upper)))
		else $error("operation not held during long write");

	// Register port answers and pointer byte writes
	a_rd_latch_view: assert property (
		sfr_rd_i && sel_latch |=> sfr_rdata_o == $past(latch_r) && sfr_hit_o)
		else $error("latch read back wrong");
	a_rd_low_view: assert property (
		sfr_rd_i && sel_low |=> sfr_hit_o
			&& sfr_rdata_o == $past(ptr_r[PMA_HIGH_LSB-1:0]))
		else $error("low pointer byte read back wrong");
	a_rd_high_view: assert property (
		sfr_rd_i && sel_high |=> sfr_hit_o
			&& sfr_rdata_o == $past(ptr_r[PMA_UPPER_LSB-1:PMA_HIGH_LSB]))
		else $error("high pointer byte read back wrong");
	a_rd_upper_pad: assert property (
		sfr_rd_i && sel_upper |=> sfr_hit_o && sfr_rdata_o[PMA_DATA_W-1:PMA_UPPER_USED] == '0
			&& sfr_rdata_o[PMA_UPPER_USED-1:0] == $past(ptr_r[PMA_PTR_W-1:PMA_UPPER_LSB]))
		else $error("upper pointer byte read back wrong");
	a_rd_unmapped: assert property (
		sfr_rd_i && !sel_any |=> sfr_rdata_o == PMA_BYTE_ZERO && !sfr_hit_o)
		else $error("unmapped read returned data");
	a_rd_idle_zero: assert property (
		!sfr_rd_i |=> sfr_rdata_o == PMA_BYTE_ZERO && !sfr_hit_o)
		else $error("read data left standing");
	a_low_byte_map: assert property (
		wr_low && !accept |=> ptr_r[PMA_HIGH_LSB-1:0] == $past(sfr_wdata_i))
		else $error("low pointer byte write lost");
	a_high_byte_map: assert property (
		wr_high && !accept |=> ptr_r[PMA_UPPER_LSB-1:PMA_HIGH_LSB] == $past(sfr_wdata_i))
		else $error("high pointer byte write lost");

	// Table write address and pointer step
	a_wr_postinc_step: assert property (
		wr_go && op_mode_i == PMA_OP_POSTINC |=>
			ptr_r[PMA_OFS_W-1:0] == 21'($past(ptr_r[PMA_OFS_W-1:0]) + PMA_OFS_ONE))
		else $error("post-increment write step wrong");
	a_wr_postdec_step: assert property (
		wr_go && op_mode_i == PMA_OP_POSTDEC |=>
			ptr_r[PMA_OFS_W-1:0] == 21'($past(ptr_r[PMA_OFS_W-1:0]) - PMA_OFS_ONE))
		else $error("post-decrement write step wrong");
	a_wr_long_addr: assert property (
		wr_long && op_mode_i != PMA_OP_PREINC |=> mem_addr_o == $past(ptr_r)
			&& mem_addr_o[0])
		else $error("long write address wrong");
	a_wr_preinc_addr: assert property (
		wr_long && op_mode_i == PMA_OP_PREINC |=> mem_addr_o == ptr_r)
		else $error("pre-increment write address wrong");
	a_wr_id_space: assert property (
		wr_long |=> mem_id_space_o == $past(ptr_r[PMA_ID_BIT]))
		else $error("space select not presented on write");

	// Completion and holding off requests
	a_mem_on_op: assert property (
		!accept |=> !mem_rd_o && !mem_wr_o)
		else $error("memory strobe without an operation");
	a_read_holds: assert property (
		state_r == PMA_ST_READ |=> $stable(ptr_r)
			|| $past(wr_low || wr_high || wr_upper))
		else $error("operation not held during read");
	a_busy_ends_done: assert property (
		$fell(busy_o) |-> op_done_o)
		else $error("busy ended without completion");

endmodule

/* File: verilog/pma_wr_pair.sv */
// Write pairing: hidden holding byte and short/long write decision
`timescale 1ns/1ps
module pma_wr_pair
	import pma_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic addr_lsb_i,
	input wire logic [PMA_DATA_W-1:0] latch_i,
	output logic short_o,
	output logic long_o,
	output logic [PMA_DATA_W-1:0] hold_o
);
	logic [PMA_DATA_W-1:0] hold_r;

	assign short_o = wr_i & ~addr_lsb_i;
	assign long_o = wr_i & addr_lsb_i;
	assign hold_o = hold_r;

	// Holding byte has no register address; only even writes load it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_r <= PMA_LATCH_RST;
		end else if (short_o) begin
			hold_r <= latch_i;
		end
	end

	a_hold_loads: assert property (@(posedge clk_i) disable iff (rst_i)
		short_o |=> hold_o == $past(latch_i))
		else $error("holding byte not loaded by even write");
	a_hold_private: assert property (@(posedge clk_i) disable iff (rst_i)
		!short_o |=> $stable(hold_o))
		else $error("holding byte changed without even write");
endmodule
